// ===== logic/srf_pkg.sv
package srf_pkg;
	// ---------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ---------------------------------------------------------------
	localparam logic [7:0] IDX_CTRL = 8'h30;
	localparam logic [7:0] IDX_STAT = 8'h31;
	localparam logic [7:0] IDX_DELAY = 8'h32;
	localparam logic [7:0] IDX_IRQ_STAT = 8'h33;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h34;
	localparam logic [7:0] IDX_LINK_CTRL = 8'h35;
	localparam logic [7:0] IDX_LINK_STAT = 8'h36;
	localparam int ADDR_W = 10;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int CTRL_RCVR_EN = 7;
	localparam int CTRL_PROC_EN = 6;
	localparam int CTRL_EDGE_CLR = 5;
	localparam int CTRL_FAULT_CLR = 4;
	localparam int STAT_EDGE = 7;
	localparam int STAT_FAULT = 6;
	localparam int DELAY_W = 4;
	localparam int IRQ_EDGE = 0;
	localparam int IRQ_FAULT = 1;
	localparam int IRQ_SYNC_REQ = 2;
	localparam int IRQ_LINK_UP = 3;
	localparam int IRQ_W = 4;
	localparam int LINK_EN = 0;
	localparam int LINK_DDC = 1;
	localparam int LSTAT_SYNC_N = 3;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [DELAY_W-1:0] DELAY_RST = 4'h0;
	localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;
	localparam logic [1:0] LINK_RST = 2'h0;

	// ---------------------------------------------------------------
	// link timing defaults
	// ---------------------------------------------------------------
	localparam int LMFC_CYCLES = 32;
	localparam int ILA_MULTIFRAMES = 4;

	typedef enum logic [2:0] {
		LS_IDLE = 3'b000,
		LS_CGS = 3'b001,
		LS_WAIT = 3'b010,
		LS_ILA = 3'b011,
		LS_DATA = 3'b100
	} srf_link_state_t;

	function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
		reg_addr = {idx, 2'b00};
	endfunction
endpackage

// ===== logic/srf_cap_if.sv
`timescale 1ns/10ps
interface srf_cap_if;
	logic rx_en;
	logic proc_en;
	logic [srf_pkg::DELAY_W-1:0] delay_sel;
	logic edge_p;
	logic fault_p;
	modport cap (input rx_en, input proc_en, input delay_sel, output edge_p, output fault_p);
	modport ctl (output rx_en, output proc_en, output delay_sel, input edge_p, input fault_p);
endinterface

// ===== logic/srf_capture.sv
`timescale 1ns/10ps
module srf_capture (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// reference pins
	input wire logic ref_i,
	input wire logic ref_late_i,
	// control side
	srf_cap_if.cap cap
);
	// ---------------------------------------------------------------
	// programmable delay line
	// ---------------------------------------------------------------
	localparam int TAPS = 1 << srf_pkg::DELAY_W;
	logic [TAPS-1:0] main_line;
	logic [TAPS-1:0] late_line;
	logic tap_q;
	logic ref_gated;
	logic late_gated;
	logic tap;
	logic late_tap;
	logic rise;

	// receiver off means the pin is ignored entirely
	assign ref_gated = ref_i & cap.rx_en;
	assign late_gated = ref_late_i & cap.rx_en;
	// RULE_01: delay tap select
	assign tap = main_line[cap.delay_sel];
	assign late_tap = late_line[cap.delay_sel];
	assign rise = tap & ~tap_q;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			main_line <= '0;
			late_line <= '0;
			tap_q <= 1'b0;
			cap.edge_p <= 1'b0;
			cap.fault_p <= 1'b0;
		end else begin
			main_line <= {main_line[TAPS-2:0], ref_gated};
			late_line <= {late_line[TAPS-2:0], late_gated};
			tap_q <= tap;
			cap.edge_p <= rise;
			// RULE_03: margin fault when the late sample misses a captured edge
			cap.fault_p <= rise & (late_tap ^ tap);
		end
	end

	cap_edge_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_01
		rise |=> cap.edge_p)
		else $error("delayed edge not reported");
	cap_fault_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_03
		cap.fault_p |-> cap.edge_p)
		else $error("fault without edge");
endmodule // srf_capture

// ===== logic/srf_sync_top.sv
`timescale 1ns/10ps
// Behaviour
// RULE_01: delay reference by 4-bit programmable tap
// RULE_02: sticky flag on each captured rising edge
// RULE_03: sticky flag on setup/hold margin fault
// RULE_04: control bit clears edge flag
// RULE_05: control bit clears fault flag
// RULE_06: control bit enables reference receiver
// RULE_07: control bit enables reference processing
// RULE_08: source synchronous, multiframe-multiple period
// RULE_09: software sweeps delay, picks centre
// RULE_10: ddc mode resets nco during ila
// RULE_11: receivers release sync in one lmfc
// RULE_12: larger multiframe eases simultaneous release
// RULE_13: captured edge realigns multiframe boundary
// RULE_14: receiver drives sync low to request
// RULE_15: k chars until boundary, then ila
// RULE_16: flags update only when both enabled
module srf_sync_top #(
	parameter int LMFC_CYCLES = srf_pkg::LMFC_CYCLES,
	parameter int ILA_MULTIFRAMES = srf_pkg::ILA_MULTIFRAMES
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// avalon-mm slave
	input wire logic [srf_pkg::ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// reference and link pins
	input wire logic ref_i,
	input wire logic ref_late_i,
	input wire logic sync_n_i,
	// link outputs
	output logic ref_receiver_enable_o,
	output logic lmfc_boundary_o,
	output logic [2:0] lane_state_o,
	output logic nco_reset_o,
	// interrupt
	output logic irq_o
);
	// ---------------------------------------------------------------
	// bus slave
	// ---------------------------------------------------------------
	localparam int LMFC_W = $clog2(LMFC_CYCLES);
	localparam logic [LMFC_W-1:0] LMFC_LAST = LMFC_W'(LMFC_CYCLES - 1);
	localparam int ILA_W = $clog2(ILA_MULTIFRAMES + 1);
	localparam logic [ILA_W-1:0] ILA_LAST = ILA_W'(ILA_MULTIFRAMES - 1);

	srf_cap_if cif ();

	logic ack;
	logic req;
	logic wr_go;
	logic rd_go;
	logic [7:0] ctrl;
	logic [srf_pkg::DELAY_W-1:0] delay_sel;
	logic edge_flag;
	logic fault_flag;
	logic [srf_pkg::IRQ_W-1:0] irq_stat;
	logic [srf_pkg::IRQ_W-1:0] irq_mask;
	logic [1:0] link_ctrl;
	logic [LMFC_W-1:0] lmfc_cnt;
	logic [ILA_W-1:0] ila_cnt;
	logic sync_n_q;
	localparam logic [LMFC_W-1:0] LMFC_ONE = LMFC_W'(1);
	localparam logic [ILA_W-1:0] ILA_ONE = ILA_W'(1);

	logic hit_ctrl;
	logic hit_stat;
	logic hit_delay;
	logic hit_irq_stat;
	logic hit_irq_mask;
	logic hit_link_ctrl;
	logic hit_link_stat;
	logic wr_ctrl;
	logic wr_delay;
	logic wr_irq_stat;
	logic wr_irq_mask;
	logic wr_link_ctrl;
	logic edge_clr_wr;
	logic fault_clr_wr;
	logic both_en;
	logic ev_edge;
	logic ev_fault;
	logic ev_sync_req;
	logic ev_link_up;
	logic link_en;
	logic ddc_en;
	logic lmfc_wrap;
	logic [7:0] next_ctrl;
	logic [1:0] next_link_ctrl;
	logic [srf_pkg::IRQ_W-1:0] irq_events;
	logic [srf_pkg::IRQ_W-1:0] irq_clear;
	logic [srf_pkg::IRQ_W-1:0] next_irq_stat;
	logic [LMFC_W-1:0] next_lmfc;
	logic [7:0] stat_byte;
	logic [7:0] link_stat_byte;
	logic [7:0] rd_byte;
	srf_pkg::srf_link_state_t link_state;
	srf_pkg::srf_link_state_t next_link_state;

	// ---------------------------------------------------------------
	// address decode
	// ---------------------------------------------------------------
	function automatic logic reg_hit(input logic [srf_pkg::ADDR_W-1:0] addr,
		input logic [7:0] idx);
		reg_hit = (addr == srf_pkg::reg_addr(idx));
	endfunction

	assign hit_ctrl = reg_hit(avs_address_i, srf_pkg::IDX_CTRL);
	assign hit_stat = reg_hit(avs_address_i, srf_pkg::IDX_STAT);
	assign hit_delay = reg_hit(avs_address_i, srf_pkg::IDX_DELAY);
	assign hit_irq_stat = reg_hit(avs_address_i, srf_pkg::IDX_IRQ_STAT);
	assign hit_irq_mask = reg_hit(avs_address_i, srf_pkg::IDX_IRQ_MASK);
	assign hit_link_ctrl = reg_hit(avs_address_i, srf_pkg::IDX_LINK_CTRL);
	assign hit_link_stat = reg_hit(avs_address_i, srf_pkg::IDX_LINK_STAT);

	// ---------------------------------------------------------------
	// bus handshake
	// ---------------------------------------------------------------
	// one wait state on every access: read data is registered in the
	// first cycle so it stands at the edge where waitrequest is low
	assign req = avs_read_i | avs_write_i;
	assign avs_waitrequest_o = req & ~ack;
	assign wr_go = avs_write_i & ack;
	assign rd_go = avs_read_i & ~ack;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ack <= 1'b0;
		end else begin
			ack <= req & ~ack;
		end
	end

	assign wr_ctrl = wr_go & hit_ctrl;
	assign wr_delay = wr_go & hit_delay;
	assign wr_irq_stat = wr_go & hit_irq_stat;
	assign wr_irq_mask = wr_go & hit_irq_mask;
	assign wr_link_ctrl = wr_go & hit_link_ctrl;

	// ---------------------------------------------------------------
	// control registers
	// ---------------------------------------------------------------
	// clear bits are strobes only: they never stay set, so a later edge
	// is not swallowed by a stale clear
	// RULE_04: edge flag clear strobe
	assign edge_clr_wr = wr_ctrl & avs_writedata_i[srf_pkg::CTRL_EDGE_CLR];
	// RULE_05: fault flag clear strobe
	assign fault_clr_wr = wr_ctrl & avs_writedata_i[srf_pkg::CTRL_FAULT_CLR];

	always_comb begin
		next_ctrl = srf_pkg::CTRL_RST;
		next_ctrl[srf_pkg::CTRL_RCVR_EN] = avs_writedata_i[srf_pkg::CTRL_RCVR_EN];
		next_ctrl[srf_pkg::CTRL_PROC_EN] = avs_writedata_i[srf_pkg::CTRL_PROC_EN];
	end

	always_comb begin
		next_link_ctrl = srf_pkg::LINK_RST;
		next_link_ctrl[srf_pkg::LINK_EN] = avs_writedata_i[srf_pkg::LINK_EN];
		next_link_ctrl[srf_pkg::LINK_DDC] = avs_writedata_i[srf_pkg::LINK_DDC];
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ctrl <= srf_pkg::CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl <= next_ctrl;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			delay_sel <= srf_pkg::DELAY_RST;
		end else if (wr_delay) begin
			delay_sel <= avs_writedata_i[srf_pkg::DELAY_W-1:0];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			irq_mask <= srf_pkg::IRQ_RST;
		end else if (wr_irq_mask) begin
			irq_mask <= avs_writedata_i[srf_pkg::IRQ_W-1:0];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			link_ctrl <= srf_pkg::LINK_RST;
		end else if (wr_link_ctrl) begin
			link_ctrl <= next_link_ctrl;
		end
	end

	// ---------------------------------------------------------------
	// capture path
	// ---------------------------------------------------------------
	// RULE_06: receiver enable bit
	assign cif.rx_en = ctrl[srf_pkg::CTRL_RCVR_EN];
	assign ref_receiver_enable_o = ctrl[srf_pkg::CTRL_RCVR_EN];
	// RULE_07: processing enable bit
	assign cif.proc_en = ctrl[srf_pkg::CTRL_PROC_EN];
	assign cif.delay_sel = delay_sel;

	srf_capture u_srf_capture (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.ref_i(ref_i),
		.ref_late_i(ref_late_i),
		.cap(cif.cap)
	);

	// RULE_16: events count only when both enabled
	assign both_en = cif.rx_en & cif.proc_en;
	assign ev_edge = cif.edge_p & both_en;
	assign ev_fault = cif.fault_p & both_en;

	// ---------------------------------------------------------------
	// sticky capture flags
	// ---------------------------------------------------------------
	// a new event wins over a clear in the same cycle
	// RULE_02: edge flag sticky set
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			edge_flag <= 1'b0;
		end else if (ev_edge) begin
			edge_flag <= 1'b1;
		end else if (edge_clr_wr) begin
			edge_flag <= 1'b0;
		end
	end

	// RULE_03: fault flag sticky set
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			fault_flag <= 1'b0;
		end else if (ev_fault) begin
			fault_flag <= 1'b1;
		end else if (fault_clr_wr) begin
			fault_flag <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// interrupt
	// ---------------------------------------------------------------
	always_comb begin
		irq_events = srf_pkg::IRQ_RST;
		irq_events[srf_pkg::IRQ_EDGE] = ev_edge;
		irq_events[srf_pkg::IRQ_FAULT] = ev_fault;
		irq_events[srf_pkg::IRQ_SYNC_REQ] = ev_sync_req;
		irq_events[srf_pkg::IRQ_LINK_UP] = ev_link_up;
	end

	assign irq_clear = wr_irq_stat ? avs_writedata_i[srf_pkg::IRQ_W-1:0] : srf_pkg::IRQ_RST;
	assign next_irq_stat = (irq_stat & ~irq_clear) | irq_events;
	assign irq_o = |(irq_stat & irq_mask);

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			irq_stat <= srf_pkg::IRQ_RST;
		end else begin
			irq_stat <= next_irq_stat;
		end
	end

	// ---------------------------------------------------------------
	// local multiframe clock
	// ---------------------------------------------------------------
	// the edge cycle counts as position zero, so a source already in
	// phase leaves the count untouched
	// RULE_13: edge realigns multiframe count
	assign lmfc_wrap = (lmfc_cnt == LMFC_LAST);
	assign next_lmfc = ev_edge ? LMFC_ONE : (lmfc_wrap ? '0 : lmfc_cnt + LMFC_ONE);

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			lmfc_cnt <= '0;
			lmfc_boundary_o <= 1'b0;
		end else begin
			lmfc_cnt <= next_lmfc;
			lmfc_boundary_o <= lmfc_wrap;
		end
	end

	// ---------------------------------------------------------------
	// link startup
	// ---------------------------------------------------------------
	// idle level of the request pin is high, so the delayed copy resets
	// high and no false request follows reset
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			sync_n_q <= 1'b1;
		end else begin
			sync_n_q <= sync_n_i;
		end
	end

	assign link_en = link_ctrl[srf_pkg::LINK_EN];
	assign ddc_en = link_ctrl[srf_pkg::LINK_DDC];
	assign ev_sync_req = link_en & sync_n_q & ~sync_n_i;

	// RULE_15: k chars until boundary, then alignment
	always_comb begin
		next_link_state = link_state;
		case (link_state)
			srf_pkg::LS_IDLE: begin
				if (!sync_n_i) begin
					next_link_state = srf_pkg::LS_CGS;
				end
			end
			srf_pkg::LS_CGS: begin
				if (sync_n_i) begin
					next_link_state = srf_pkg::LS_WAIT;
				end
			end
			srf_pkg::LS_WAIT: begin
				if (!sync_n_i) begin
					next_link_state = srf_pkg::LS_CGS;
				end else if (lmfc_wrap) begin
					next_link_state = srf_pkg::LS_ILA;
				end
			end
			srf_pkg::LS_ILA: begin
				if (!sync_n_i) begin
					next_link_state = srf_pkg::LS_CGS;
				end else if (lmfc_wrap && ila_cnt == ILA_LAST) begin
					next_link_state = srf_pkg::LS_DATA;
				end
			end
			srf_pkg::LS_DATA: begin
				if (!sync_n_i) begin
					next_link_state = srf_pkg::LS_CGS;
				end
			end
			default: begin
				next_link_state = srf_pkg::LS_IDLE;
			end
		endcase
		if (!link_en) begin
			next_link_state = srf_pkg::LS_IDLE;
		end
	end

	assign ev_link_up = (link_state == srf_pkg::LS_ILA) & (next_link_state == srf_pkg::LS_DATA);
	assign lane_state_o = link_state;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			link_state <= srf_pkg::LS_IDLE;
		end else begin
			link_state <= next_link_state;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ila_cnt <= '0;
		end else if (link_state != srf_pkg::LS_ILA) begin
			ila_cnt <= '0;
		end else if (lmfc_wrap) begin
			ila_cnt <= ila_cnt + ILA_ONE;
		end
	end

	// RULE_10: nco reset during alignment
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			nco_reset_o <= 1'b0;
		end else begin
			nco_reset_o <= (link_state == srf_pkg::LS_ILA) & ddc_en;
		end
	end

	// ---------------------------------------------------------------
	// read back
	// ---------------------------------------------------------------
	assign stat_byte = (8'(edge_flag) << srf_pkg::STAT_EDGE)
		| (8'(fault_flag) << srf_pkg::STAT_FAULT);
	assign link_stat_byte = (8'(sync_n_q) << srf_pkg::LSTAT_SYNC_N) | 8'(link_state);
	assign rd_byte = hit_ctrl ? ctrl
		: hit_stat ? stat_byte
		: hit_delay ? 8'(delay_sel)
		: hit_irq_stat ? 8'(irq_stat)
		: hit_irq_mask ? 8'(irq_mask)
		: hit_link_ctrl ? 8'(link_ctrl)
		: hit_link_stat ? link_stat_byte
		: 8'h00;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			avs_readdata_o <= 32'h00000000;
		end else if (rd_go) begin
			avs_readdata_o <= 32'(rd_byte);
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb_main @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);

	edge_set_a: assert property (ev_edge |=> edge_flag) // RULE_02
		else $error("edge flag not set");
	edge_hold_a: assert property (edge_flag && !edge_clr_wr |=> edge_flag) // RULE_02
		else $error("edge flag dropped by itself");
	fault_set_a: assert property (ev_fault |=> fault_flag) // RULE_03
		else $error("fault flag not set");
	edge_clr_a: assert property (edge_clr_wr && !ev_edge |=> !edge_flag) // RULE_04
		else $error("edge flag not cleared");
	fault_clr_a: assert property (fault_clr_wr && !ev_fault |=> !fault_flag) // RULE_05
		else $error("fault flag not cleared");
	gate_flags_a: assert property (!both_en && !edge_flag |=> !edge_flag) // RULE_16
		else $error("edge flag set while disabled");
	lmfc_align_a: assert property (ev_edge |=> lmfc_cnt == LMFC_ONE) // RULE_13
		else $error("multiframe count not realigned");
	nco_ila_a: assert property (link_state == srf_pkg::LS_ILA && ddc_en |=> nco_reset_o) // RULE_10
		else $error("nco reset missing in alignment");
	ila_start_a: assert property (link_state == srf_pkg::LS_WAIT && link_en && sync_n_i // RULE_15
		&& lmfc_wrap |=> link_state == srf_pkg::LS_ILA)
		else $error("alignment not started at boundary");

	edge_seen_c: cover property (ev_edge);
	fault_seen_c: cover property (ev_fault);
	link_up_c: cover property (ev_link_up);
	clear_seen_c: cover property (edge_clr_wr && edge_flag);
endmodule // srf_sync_top

// ===== verification/srf_far_model.sv
`timescale 1ns/10ps
module srf_far_model (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// fault request
	input wire logic late_i,
	// sync request from the bench
	input wire logic sync_req_i,
	// far side pins
	output logic ref_o = 1'b0,
	output logic ref_late_o = 1'b0,
	output logic sync_n_o = 1'b1
);
	logic [5:0] cnt = 6'h00;
	always_ff @(posedge ref_clk_i) begin
		cnt <= rst_i ? 6'h00 : cnt + 6'h01;
		ref_o <= cnt == 6'h3F;
		// late copy misses the pulse to fake a margin fault
		ref_late_o <= ~late_i & (cnt == 6'h3F);
		// one receiver, sync held low while the bench requests and released once it drops
		sync_n_o <= rst_i | ~sync_req_i;
	end
endmodule // srf_far_model

// ===== verification/srf_sync_top_tb.sv
`timescale 1ns/10ps
module srf_sync_top_tb;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic late = 1'b0;
	logic [9:0] adr = 10'h000;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdata;
	logic [31:0] seed = 32'h10D79;
	logic wt, rs, ls, sn, rx, irq, lb, nco;
	logic [2:0] ln;
	logic sreq = 1'b0;
	logic lchk = 1'b0;
	int ncyc = 0;
	int gap = 0;
	logic [31:0] eq[$];
	logic [31:0] mq[$];
	int failures = 0;
	int checked = 0;
	always #50 ref_clk_i = ~ref_clk_i;
	srf_far_model u_srf_far_model (.ref_clk_i, .rst_i, .late_i(late), .sync_req_i(sreq), .ref_o(rs),
		.ref_late_o(ls), .sync_n_o(sn));
	srf_sync_top u_srf_sync_top (.ref_clk_i, .rst_i, .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wt), .ref_i(rs), .ref_late_i(ls), .sync_n_i(sn),
		.ref_receiver_enable_o(rx), .lmfc_boundary_o(lb), .lane_state_o(ln),
		.nco_reset_o(nco), .irq_o(irq));
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction
	task automatic finish_test();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// read expectations are queued with their field mask
	task automatic bus(input logic [7:0] i, input logic w, input logic [31:0] d,
		input logic [31:0] m);
		int n;
		@(posedge ref_clk_i);
		adr <= {i, 2'b00};
		wr <= w;
		rd <= !w;
		wd <= d;
		if (!w) begin
			eq.push_back(d);
			mq.push_back(m);
		end
		for (n = 0; n < 50; n++) begin
			@(posedge ref_clk_i);
			if (wt === 1'b0) break;
		end
		rd <= 1'b0;
		wr <= 1'b0;
		if (n == 50) begin
			failures++;
			finish_test();
		end
	endtask
	always @(posedge ref_clk_i) begin
		if (rd === 1'b1 && wt === 1'b0) cmp(rdata & mq.pop_front(), eq.pop_front());
		if (nco === 1'b1) ncyc++;
		if (lb === 1'b1) begin
			if (lchk) cmp(32'(gap), 32'(srf_pkg::LMFC_CYCLES));
			gap = 1;
		end else begin
			gap++;
		end
	end
	initial begin
		repeat (2) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		bus(8'h30, 0, 0, 32'hFF);
		repeat (70) @(posedge ref_clk_i);
		bus(8'h31, 0, 0, 32'hC0);
		bus(8'h34, 1, 32'h1, 0);
		bus(8'h30, 1, 32'hC0, 0);
		repeat (70) @(posedge ref_clk_i);
		cmp({31'h0, rx}, 32'h1);
		cmp({31'h0, irq}, 32'h1);
		bus(8'h31, 0, 32'h80, 32'hC0);
		late <= 1'b1;
		repeat (70) @(posedge ref_clk_i);
		late <= 1'b0;
		bus(8'h31, 0, 32'hC0, 32'hC0);
		bus(8'h30, 1, 32'h20, 0);
		bus(8'h31, 0, 32'h40, 32'hC0);
		bus(8'h30, 1, 32'h10, 0);
		bus(8'h31, 0, 0, 32'hC0);
		bus(8'h33, 1, 32'hF, 0);
		bus(8'h33, 0, 0, 32'hF);
		cmp({31'h0, irq}, 32'h0);
		for (int k = 0; k < 4; k++) begin
			seed = xs(seed);
			bus(8'h32, 1, seed & 32'hF, 0);
			bus(8'h32, 0, seed & 32'hF, 32'hF);
		end
		bus(8'h3F, 0, 0, 0);
		lchk <= 1'b1;
		bus(8'h35, 1, 32'h3, 0);
		sreq <= 1'b1;
		repeat (10) @(posedge ref_clk_i);
		sreq <= 1'b0;
		repeat (200) @(posedge ref_clk_i);
		bus(8'h36, 0, 32'hC, 32'hF);
		bus(8'h33, 0, 32'hC, 32'hC);
		cmp({29'h0, ln}, 32'h4);
		cmp(32'(ncyc), 32'(srf_pkg::ILA_MULTIFRAMES * srf_pkg::LMFC_CYCLES));
		finish_test();
	end
endmodule // srf_sync_top_tb
